/* File: include/ivp_cfg.svh */
// Constants for the interrupt vector and priority block.
`ifndef IVP_CFG_SVH
`define IVP_CFG_SVH
`define IVP_NREQ 24
`define IVP_LVL_BASE 16'h0079
`define IVP_LVL_NREG 6
`define IVP_LVL_RST 8'hff
`define IVP_VEC_TOP 16'hfffa
`define IVP_UNUSED_A 11
`define IVP_UNUSED_B 17
`define IVP_UNUSED_C 21
`define IVP_RD_UNMAPPED 8'h00
`endif

/* File: include/ivp_pkg.sv */
// Types for the interrupt vector and priority block.
package ivp_pkg;
    // Request lines from the peripherals, all on the system clock.
    typedef struct packed {
        logic [7:0] ext_irq;
        logic uart_sio;
        logic ctim0_lo;
        logic ctim0_hi;
        logic lin_rx;
        logic lin_tx;
        logic ppg1_lo;
        logic ppg1_hi;
        logic ppg0_hi;
        logic ppg0_lo;
        logic ctim1_hi;
        logic ppg16;
        logic i2c;
        logic adc;
        logic tbt;
        logic watch;
        logic ctim1_lo;
        logic flash;
    } ivp_src_t;
    // Byte access from the CPU core to the level-setting registers.
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ivp_acc_t;
    // Winning request presented to the CPU core.
    typedef struct packed {
        logic valid;
        logic [4:0] num;
        logic [1:0] level;
        logic [15:0] vec_hi;
        logic [15:0] vec_lo;
    } ivp_win_t;
endpackage : ivp_pkg

/* File: rtl/ivp_top.sv */
// Interrupt request mapping, level registers and priority resolution.
`timescale 1ns/100ps
`include "ivp_cfg.svh"
// Overview of operation
// - Each of requests 0 to 23 has a two-bit level field and equal levels resolve to the lowest request number.
// - Compound timer 0 raises request 5 for its lower half and request 6 for its upper half.
// - Compound timer 1 raises request 14 for its upper half and request 22 for its lower half.
// - Pulse generator 1 maps lower to 9 and upper to 10, pulse generator 0 maps upper to 12 and lower to 13.
// - Reading an unimplemented address gives the fixed value 0x00.
// - Six level registers from 0x79 to 0x7e hold four fields each and reset to all ones.
module ivp_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input ivp_pkg::ivp_src_t src,
    input ivp_pkg::ivp_acc_t acc,
    output logic [7:0] rdata,
    output ivp_pkg::ivp_win_t win
);
    import ivp_pkg::*;

    logic rst_meta_ff;
    logic rst_n_ff;
    logic [`IVP_LVL_NREG-1:0][7:0] lvl_ff;
    logic [`IVP_NREQ-1:0] req;
    logic [3:0] ext_req;
    logic [`IVP_NREQ*2-1:0] lvl_flat;
    ivp_win_t nxt_win;
    logic [7:0] nxt_rdata;

    // Release of the asynchronous reset is retimed so no flop sees a runt edge.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // Level field of request n, four fields packed per byte.
    function automatic logic [1:0] lvl_of(input logic [`IVP_NREQ*2-1:0] f, input int n);
        lvl_of = f[2*n +: 2];
    endfunction : lvl_of

    // Register index hit by an address, or -1 when outside the level block.
    function automatic int lvl_idx(input logic [15:0] a);
        if (a >= `IVP_LVL_BASE && a < `IVP_LVL_BASE + 16'(`IVP_LVL_NREG)) begin
            lvl_idx = int'(a - `IVP_LVL_BASE);
        end else begin
            lvl_idx = -1;
        end
    endfunction : lvl_idx

    assign lvl_flat = lvl_ff;

    // shared external channels
    // Channels n and n+4 share one request, so either one raising it is enough.
    for (genvar g = 0; g < 4; g++) begin : g_ext
        assign ext_req[g] = src.ext_irq[g] | src.ext_irq[g+4];
    end

    // Source to request number mapping; unused numbers are tied low.
    always_comb begin
        req = '0;
        req[3:0] = ext_req;
        req[4] = src.uart_sio;
        req[5] = src.ctim0_lo;
        req[6] = src.ctim0_hi;
        req[7] = src.lin_rx;
        req[8] = src.lin_tx;
        req[9] = src.ppg1_lo;
        req[10] = src.ppg1_hi;
        req[12] = src.ppg0_hi;
        req[13] = src.ppg0_lo;
        req[14] = src.ctim1_hi;
        req[15] = src.ppg16;
        req[16] = src.i2c;
        req[18] = src.adc;
        req[19] = src.tbt;
        req[20] = src.watch;
        req[22] = src.ctim1_lo;
        req[23] = src.flash;
    end

    // Level registers; writes outside the block are dropped since software never makes them.
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            lvl_ff <= {`IVP_LVL_NREG{`IVP_LVL_RST}};
        end else if (ce && acc.wr && lvl_idx(acc.addr) >= 0) begin
            lvl_ff[lvl_idx(acc.addr)] <= acc.wdata;
        end
    end

    // Read data; any other address returns a fixed filler the CPU must not rely on.
    always_comb begin
        if (lvl_idx(acc.addr) >= 0) begin
            nxt_rdata = lvl_ff[lvl_idx(acc.addr)];
        end else begin
            nxt_rdata = `IVP_RD_UNMAPPED;
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= nxt_rdata;
        end
    end

    // Pick the lowest level value; strict compare keeps the lower number on a tie.
    always_comb begin
        nxt_win = '0;
        for (int n = 0; n < `IVP_NREQ; n++) begin
            if (req[n] && (!nxt_win.valid || lvl_of(lvl_flat, n) < nxt_win.level)) begin
                nxt_win.valid = 1'b1;
                nxt_win.num = 5'(n);
                nxt_win.level = lvl_of(lvl_flat, n);
            end
        end
        // descending two-byte vectors
        // An idle output carries no vector, so the core never sees a stale address.
        if (nxt_win.valid) begin
            nxt_win.vec_hi = `IVP_VEC_TOP - 16'({nxt_win.num, 1'b0});
            nxt_win.vec_lo = nxt_win.vec_hi + 16'h0001;
        end
    end

    // The winner is registered so the CPU samples a stable vector for a whole cycle.
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            win <= '0;
        end else if (ce) begin
            win <= nxt_win;
        end
    end

    property p_tie_low_num;
        @(posedge clk) disable iff (!rst_n_ff)
        (ce && req[1] && req[2] && req[0] == 1'b0 && lvl_of(lvl_flat, 1) == lvl_of(lvl_flat, 2)
            && lvl_of(lvl_flat, 1) == 2'h0) |=> (win.valid && win.num == 5'h01);
    endproperty
    a_tie_low_num: assert property (p_tie_low_num) else $error("Tie not won by lower number.");

    property p_ctim0_hi;
        @(posedge clk) disable iff (!rst_n_ff)
        (ce && src.ctim0_hi && req[5:0] == 6'h00 && lvl_of(lvl_flat, 6) == 2'h0)
            |=> (win.num == 5'h06 && win.vec_hi == 16'hffee);
    endproperty
    a_ctim0_hi: assert property (p_ctim0_hi) else $error("Timer 0 upper not request 6.");

    property p_ctim1_lo;
        @(posedge clk) disable iff (!rst_n_ff)
        (ce && src.ctim1_lo && req[21:0] == 22'h0 && lvl_of(lvl_flat, 22) == 2'h0)
            |=> (win.num == 5'h16 && win.vec_lo == 16'hffcf);
    endproperty
    a_ctim1_lo: assert property (p_ctim1_lo) else $error("Timer 1 lower not request 22.");

    property p_ppg0_lo;
        @(posedge clk) disable iff (!rst_n_ff)
        (ce && src.ppg0_lo && req[12:0] == 13'h0 && lvl_of(lvl_flat, 13) == 2'h0)
            |=> (win.num == 5'h0d);
    endproperty
    a_ppg0_lo: assert property (p_ppg0_lo) else $error("Pulse gen 0 lower not request 13.");

    property p_ppg1_hi;
        @(posedge clk) disable iff (!rst_n_ff)
        (ce && src.ppg1_hi && req[9:0] == 10'h000 && lvl_of(lvl_flat, 10) == 2'h0)
            |=> (win.num == 5'h0a && win.vec_hi == 16'hffe6);
    endproperty
    a_ppg1_hi: assert property (p_ppg1_hi) else $error("Pulse gen 1 upper not request 10.");

    property p_rd_lvl;
        @(posedge clk) disable iff (!rst_n_ff)
        (ce && !acc.wr && acc.addr == `IVP_LVL_BASE) |=> (rdata == $past(lvl_ff[0]));
    endproperty
    a_rd_lvl: assert property (p_rd_lvl) else $error("Level register read mismatch.");

    property p_lvl_reset;
        @(posedge clk) disable iff (!rst_n_ff)
        $rose(rst_n_ff) |-> (lvl_ff == {`IVP_LVL_NREG{`IVP_LVL_RST}});
    endproperty
    a_lvl_reset: assert property (p_lvl_reset) else $error("Level registers not all ones.");

    property p_ext_share;
        @(posedge clk) disable iff (!rst_n_ff)
        (ce && src.ext_irq[4] && lvl_of(lvl_flat, 0) == 2'h0) |=> (win.valid && win.num == 5'h00);
    endproperty
    a_ext_share: assert property (p_ext_share) else $error("Channel 4 not on request 0.");

    property p_unused;
        @(posedge clk) disable iff (!rst_n_ff)
        win.valid |-> (win.num != 5'h0b && win.num != 5'h11 && win.num != 5'h15
            && win.vec_hi == 16'hfffa - 16'({win.num, 1'b0}));
    endproperty
    a_unused: assert property (p_unused) else $error("Unused request won or bad vector.");

    // With no request the output must go fully quiet, vectors included.
    property p_idle;
        @(posedge clk) disable iff (!rst_n_ff)
        (ce && req == '0) |=> (!win.valid && win.vec_hi == 16'h0000 && win.vec_lo == 16'h0000);
    endproperty
    a_idle: assert property (p_idle) else $error("Idle output not cleared.");

    // Clock enable low must freeze the winner, the read data and the levels.
    property p_ce_hold;
        @(posedge clk) disable iff (!rst_n_ff)
        !ce |=> ($stable(win) && $stable(rdata) && $stable(lvl_ff));
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("State moved while enable low.");
endmodule : ivp_top

/* File: verification/ivp_cpu_model.sv */
// Far-side model of the CPU core that takes the winning vector.
`timescale 1ns/100ps
module ivp_cpu_model
    import ivp_pkg::*;
(
    input ivp_pkg::ivp_win_t win,
    output logic [15:0] fetch
);
    // The core fetches from the upper vector byte only while a request is shown.
    assign fetch = win.valid ? win.vec_hi : 16'h0000;
endmodule : ivp_cpu_model

/* File: verification/tb.sv */
// Self-checking bench for the interrupt vector and priority block.
`timescale 1ns/100ps
`include "ivp_cfg.svh"
module tb;
    import ivp_pkg::*;
    typedef struct {int due; bit rd; ivp_win_t w; logic [7:0] d;} ivp_note_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [24:0] src = '0;
    ivp_acc_t acc = '0;
    logic [7:0] rdata;
    ivp_win_t win;
    logic [15:0] fetch;
    logic [1:0] lvl [24];
    int map [17] = '{23, 22, 20, 19, 18, 16, 15, 14, 13, 12, 10, 9, 8, 7, 6, 5, 4};
    ivp_note_t q [$];
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int seed = 32'haaf8cf9c;
    logic [7:0] rv;
    ivp_win_t last_w = '0;

    ivp_top i_ivp_top (.clk(clk), .nrst(nrst), .ce(ce), .src(ivp_src_t'(src)), .acc(acc),
        .rdata(rdata), .win(win));
    ivp_cpu_model i_ivp_cpu_model (.win(win), .fetch(fetch));

    // Clock of 10 ns period.
    always #5 clk = ~clk;

    // Cycle count; a run far longer than the tests need is cut short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            errors++;
            results();
        end
    end

    // Expected winner: lowest level value first, then lowest request number.
    function automatic ivp_win_t expw(input logic [24:0] s);
        logic [23:0] r;
        ivp_win_t w;
        r = '0;
        w = '0;
        for (int i = 0; i < 8; i++) if (s[17 + i]) r[i % 4] = 1'b1;
        for (int i = 0; i < 17; i++) if (s[i]) r[map[i]] = 1'b1;
        for (int l = 3; l >= 0; l--) for (int n = 23; n >= 0; n--) if (r[n] && lvl[n] == l)
            w = '{1'b1, 5'(n), 2'(l), 16'hfffa - 16'(2 * n), 16'hfffb - 16'(2 * n)};
        return w;
    endfunction : expw

    // Byte read; the data shows one cycle after the address.
    task automatic rd(input logic [15:0] a, input logic [7:0] d);
        acc = '{1'b0, a, 8'h00};
        q.push_back('{cyc + 1, 1'b1, ivp_win_t'(0), d});
        @(posedge clk) #1;
    endtask : rd

    // Byte write; always followed by a read, which drops the strobe.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        acc = '{1'b1, a, d};
        for (int j = 0; j < 4; j++) lvl[4 * (a - 16'h0079) + j] = d[2 * j +: 2];
        @(posedge clk) #1;
    endtask : wr

    // Present a request mix and note the winner due after the next edge.
    task automatic chk(input logic [24:0] s);
        src = s;
        last_w = expw(s);
        q.push_back('{cyc + 1, 1'b0, last_w, 8'h00});
        @(posedge clk) #1;
    endtask : chk

    // Enable low for one edge: the winner holds and a level write is dropped.
    // The caller follows with a read, which lowers the write strobe.
    task automatic hold(input logic [24:0] s);
        ce = 1'b0;
        src = s;
        acc = '{1'b1, 16'h0079, 8'h5a};
        q.push_back('{cyc + 1, 1'b0, last_w, 8'h00});
        @(posedge clk) #1;
        ce = 1'b1;
    endtask : hold

    task automatic results();
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    // Monitor: compare the oldest note once its cycle has come.
    always @(negedge clk) begin
        if (q.size() > 0 && q[0].due == cyc) begin
            n_compared++;
            if (q[0].rd && rdata !== q[0].d) begin
                $display("[ERR] %0t read %h expected %h", $time, rdata, q[0].d);
                errors++;
            end
            if (!q[0].rd && (win !== q[0].w || fetch !== q[0].w.vec_hi)) begin
                $display("[ERR] %0t winner %h expected %h", $time, win, q[0].w);
                errors++;
            end
            void'(q.pop_front());
        end
    end

    // Main sequence.
    initial begin
        for (int i = 0; i < 24; i++) lvl[i] = 2'd3;
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        for (int a = 16'h0079; a <= 16'h007e; a++) rd(16'(a), 8'hff);
        rd(16'h007f, `IVP_RD_UNMAPPED);
        // Each source alone shows its own request number and vector.
        for (int i = 0; i < 25; i++) chk(25'(1) << i);
        chk('1);
        chk('0);
        // All levels to zero, then each source alone and a tie on requests 1 and 2.
        for (int a = 16'h0079; a <= 16'h007e; a++) begin
            wr(16'(a), 8'h00);
            rd(16'(a), 8'h00);
        end
        for (int i = 0; i < 25; i++) chk(25'(1) << i);
        chk(25'h0c0000);
        hold(25'h000001);
        rd(16'h0079, 8'h00);
        // Random levels, read back, then random request mixes.
        repeat (4) begin
            for (int a = 16'h0079; a <= 16'h007e; a++) begin
                rv = 8'($random(seed));
                wr(16'(a), rv);
                rd(16'(a), rv);
            end
            repeat (30) chk(25'($random(seed)));
        end
        results();
    end
endmodule : tb
